// ===== rtl/scpr_bit_mem.sv
// Single-bit-wide store with registered read data
`timescale 1ns/100ps
module scpr_bit_mem #(
  parameter int AW = 8
) (
  input  wire logic mclk_i,
  scpr_mem_if.mem   mem_if
);
  logic [(1<<AW)-1:0] store_q;
  logic [(1<<AW)-1:0] store_d;
  logic               rd_q;
  logic               rd_d;

  always_comb begin
    store_d = store_q;
    if (mem_if.wr_en) begin
      store_d[mem_if.wr_addr] = mem_if.wr_data;
    end
    rd_d = store_q[mem_if.rd_addr];
  end

  always_ff @(posedge mclk_i) begin
    store_q <= store_d;
    rd_q    <= rd_d;
  end

  assign mem_if.rd_data = rd_q;
endmodule // scpr_bit_mem

// ===== rtl/scpr_readout.sv
// Readout, cascade and scan control of the serial configuration memory
`timescale 1ns/100ps
module scpr_readout
  import scpr_pkg::*;
#(
  parameter int AW = scpr_pkg::CNT_W
) (
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  input  wire logic cfg_clk_i,
  input  wire logic cfg_clk_sel_i,
  input  wire logic oe_reset_i,
  input  wire logic ce_n_i,
  input  wire logic tck_i,
  input  wire logic tms_i,
  input  wire logic tdi_i,
  output logic      serial_data_out_o,
  output logic      serial_data_oe_n_o,
  output logic      oe_reset_o,
  output logic      oe_reset_oe_n_o,
  output logic      chain_enable_out_n_o,
  output logic      fpga_config_pulse_o,
  output logic      fpga_config_pulse_oe_n_o,
  output logic      tdo_o,
  output logic      in_system_prog_state_o
);
  import scpr_pkg::*;

  localparam logic [AW-1:0] LAST_ADDRESS_VALUE = '1;

  scpr_mem_if #(.AW(AW)) mem_bus ();

  scpr_bit_mem #(.AW(AW)) u_mem (
    .mclk_i (mclk_i),
    .mem_if (mem_bus.mem)
  );

  // Pin synchronisers
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] s1_q;
  logic [SYNC_W-1:0] s2_q;
  logic [SYNC_W-1:0] s3_q;
  assign pin_raw = {tdi_i, tms_i, tck_i, ce_n_i, oe_reset_i, cfg_clk_sel_i, cfg_clk_i};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
        end
      end
    end
  endgenerate

  logic cclk_rise;
  logic tck_rise;
  logic tck_fall;
  logic oe_hi;
  logic ce_lo;
  assign cclk_rise = s2_q[PIN_CCLK] & ~s3_q[PIN_CCLK];
  assign tck_rise  = s2_q[PIN_TCK] & ~s3_q[PIN_TCK];
  assign tck_fall  = ~s2_q[PIN_TCK] & s3_q[PIN_TCK];
  assign oe_hi     = s2_q[PIN_OE];
  assign ce_lo     = ~s2_q[PIN_CE_N];

  // State
  logic [AW-1:0]   addr_q,    addr_d;
  logic            past_q,    past_d;
  logic [7:0]      por_q,     por_d;
  logic [7:0]      cfp_q,     cfp_d;
  scpr_tap_type    tap_q,     tap_d;
  logic [IR_W-1:0] ir_sh_q,   ir_sh_d;
  logic [IR_W-1:0] ir_q,      ir_d;
  logic            dr_q,      dr_d;
  logic            isp_q,     isp_d;
  logic            clamp_q,   clamp_d;
  logic [AW-1:0]   wptr_q,    wptr_d;
  logic            wen_q,     wen_d;
  logic            wdat_q,    wdat_d;
  logic            sdo_q,     sdo_d;
  logic            sdo_oen_q, sdo_oen_d;
  logic            ceo_n_q,   ceo_n_d;
  logic            oe_oen_q,  oe_oen_d;
  logic            cfp_oen_q, cfp_oen_d;
  logic            tdo_q,     tdo_d;

  always_comb begin
    addr_d    = addr_q;
    past_d    = past_q;
    por_d     = (por_q != 8'h00) ? por_q - 8'h01 : por_q;
    cfp_d     = (cfp_q != 8'h00) ? cfp_q - 8'h01 : cfp_q;
    tap_d     = tap_q;
    ir_sh_d   = ir_sh_q;
    ir_d      = ir_q;
    dr_d      = dr_q;
    isp_d     = isp_q;
    clamp_d   = clamp_q;
    wptr_d    = wptr_q;
    wen_d     = 1'b0;
    wdat_d    = wdat_q;
    tdo_d     = tdo_q;

    // Address counter
    if (!oe_hi || !ce_lo) begin
      addr_d = '0;
      past_d = 1'b0;
    end else if (cclk_rise && s2_q[PIN_CSEL]) begin
      addr_d = addr_q + {{(AW-1){1'b0}}, 1'b1};
      if (addr_q == LAST_ADDRESS_VALUE || past_q) begin
        past_d = 1'b1;
        addr_d = addr_q;
      end
    end

    // Scan port
    if (tck_rise) begin
      unique case (tap_q)
        TAP_RESET:     tap_d = s2_q[PIN_TMS] ? TAP_RESET    : TAP_IDLE;
        TAP_IDLE:      tap_d = s2_q[PIN_TMS] ? TAP_SEL_DR   : TAP_IDLE;
        TAP_SEL_DR:    tap_d = s2_q[PIN_TMS] ? TAP_SEL_IR   : TAP_CAPT_DR;
        TAP_CAPT_DR:   tap_d = s2_q[PIN_TMS] ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_SHIFT_DR:  tap_d = s2_q[PIN_TMS] ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_EXIT1_DR:  tap_d = s2_q[PIN_TMS] ? TAP_UPDATE_DR : TAP_PAUSE_DR;
        TAP_PAUSE_DR:  tap_d = s2_q[PIN_TMS] ? TAP_EXIT2_DR : TAP_PAUSE_DR;
        TAP_EXIT2_DR:  tap_d = s2_q[PIN_TMS] ? TAP_UPDATE_DR : TAP_SHIFT_DR;
        TAP_UPDATE_DR: tap_d = s2_q[PIN_TMS] ? TAP_SEL_DR   : TAP_IDLE;
        TAP_SEL_IR:    tap_d = s2_q[PIN_TMS] ? TAP_RESET    : TAP_CAPT_IR;
        TAP_CAPT_IR:   tap_d = s2_q[PIN_TMS] ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_SHIFT_IR:  tap_d = s2_q[PIN_TMS] ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_EXIT1_IR:  tap_d = s2_q[PIN_TMS] ? TAP_UPDATE_IR : TAP_PAUSE_IR;
        TAP_PAUSE_IR:  tap_d = s2_q[PIN_TMS] ? TAP_EXIT2_IR : TAP_PAUSE_IR;
        TAP_EXIT2_IR:  tap_d = s2_q[PIN_TMS] ? TAP_UPDATE_IR : TAP_SHIFT_IR;
        TAP_UPDATE_IR: tap_d = s2_q[PIN_TMS] ? TAP_SEL_DR   : TAP_IDLE;
      endcase
      unique case (tap_q)
        TAP_RESET: begin
          ir_d    = IR_RESET_VAL;
          isp_d   = 1'b0;
          clamp_d = 1'b0;
        end
        TAP_CAPT_IR:  ir_sh_d = IR_CAPTURE;
        TAP_SHIFT_IR: ir_sh_d = {s2_q[PIN_TDI], ir_sh_q[IR_W-1:1]};
        TAP_CAPT_DR:  dr_d    = 1'b0;
        TAP_SHIFT_DR: dr_d    = s2_q[PIN_TDI];
        TAP_UPDATE_IR: begin
          ir_d    = ir_sh_q;
          clamp_d = (ir_sh_q == INS_CLAMP);
          if (ir_sh_q == INS_CONFIG) begin
            cfp_d = 8'(CFG_PULSE_CYC);
          end
          if (ir_sh_q == INS_ISP_EN) begin
            isp_d  = 1'b1;
            wptr_d = '0;
          end
          if (ir_sh_q == INS_ISP_DIS) begin
            isp_d = 1'b0;
          end
        end
        TAP_UPDATE_DR: begin
          if (isp_q && ir_q == INS_PROGRAM) begin
            wen_d  = 1'b1;
            wdat_d = dr_q;
            wptr_d = wptr_q + {{(AW-1){1'b0}}, 1'b1};
          end
        end
        default: ;
      endcase
    end
    if (tck_fall) begin
      tdo_d = (tap_q == TAP_SHIFT_IR) ? ir_sh_q[0] : dr_q;
    end

    // Pins
    sdo_d     = mem_bus.rd_data;
    sdo_oen_d = !(oe_hi && ce_lo && (!isp_q || clamp_q));
    ceo_n_d   = !(oe_hi && ce_lo && past_q);
    oe_oen_d  = (por_q == 8'h00);
    cfp_oen_d = (cfp_q == 8'h00);
  end

  assign mem_bus.rd_addr = addr_q;
  assign mem_bus.wr_en   = wen_q;
  assign mem_bus.wr_addr = wptr_q - {{(AW-1){1'b0}}, 1'b1};
  assign mem_bus.wr_data = wdat_q;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      addr_q    <= '0;
      past_q    <= 1'b0;
      por_q     <= 8'(RST_HOLD_CYC);
      cfp_q     <= 8'h00;
      tap_q     <= TAP_RESET;
      ir_sh_q   <= IR_RESET_VAL;
      ir_q      <= IR_RESET_VAL;
      dr_q      <= 1'b0;
      isp_q     <= 1'b0;
      clamp_q   <= 1'b0;
      wptr_q    <= '0;
      wen_q     <= 1'b0;
      wdat_q    <= 1'b0;
      sdo_q     <= 1'b0;
      sdo_oen_q <= 1'b1;
      ceo_n_q   <= 1'b1;
      oe_oen_q  <= 1'b0;
      cfp_oen_q <= 1'b1;
      tdo_q     <= 1'b1;
    end else begin
      addr_q    <= addr_d;
      past_q    <= past_d;
      por_q     <= por_d;
      cfp_q     <= cfp_d;
      tap_q     <= tap_d;
      ir_sh_q   <= ir_sh_d;
      ir_q      <= ir_d;
      dr_q      <= dr_d;
      isp_q     <= isp_d;
      clamp_q   <= clamp_d;
      wptr_q    <= wptr_d;
      wen_q     <= wen_d;
      wdat_q    <= wdat_d;
      sdo_q     <= sdo_d;
      sdo_oen_q <= sdo_oen_d;
      ceo_n_q   <= ceo_n_d;
      oe_oen_q  <= oe_oen_d;
      cfp_oen_q <= cfp_oen_d;
      tdo_q     <= tdo_d;
    end
  end

  // Open-drain pins only ever drive low
  assign serial_data_out_o        = sdo_q;
  assign serial_data_oe_n_o       = sdo_oen_q;
  assign oe_reset_o               = 1'b0;
  assign oe_reset_oe_n_o          = oe_oen_q;
  assign chain_enable_out_n_o     = ceo_n_q;
  assign fpga_config_pulse_o      = 1'b0;
  assign fpga_config_pulse_oe_n_o = cfp_oen_q;
  assign tdo_o                    = tdo_q;
  assign in_system_prog_state_o   = isp_q;
endmodule // scpr_readout

// ===== shared/scpr_mem_if.sv
// Link between the readout logic and its bit store
`timescale 1ns/100ps
interface scpr_mem_if #(parameter int AW = 8);
  logic [AW-1:0] rd_addr;
  logic          rd_data;
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic          wr_data;
  modport ctrl (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
  modport mem  (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface

// ===== shared/scpr_pkg.sv
// Constants and types for the serial configuration memory readout
// What this block does
// - With the configuration clock selected, chip enable low and output-enable/reset high, the address counter steps on each rising edge up to its last address.
// - With output-enable/reset low the counter is held in reset and the serial data output floats.
// - The output-enable/reset line is open drain and is pulled low by the device for as long as its own reset lasts.
// - With chip enable high the device idles in standby, clears its counter and floats its data output.
// - The configuration-trigger scan instruction pulses the open-drain configuration pulse output low.
// - Chain enable goes low only with chip enable low, output-enable/reset high and the counter past its last address.
// - Chain enable returns high three mclk_i cycles after output-enable/reset goes low or chip enable goes high.
// - In the in-system programming state the serial data output floats unless the pins are clamped.
// - The test access port state machine moves on the mode-select value sampled at each rising test clock edge.
package scpr_pkg;
  localparam int          CLK_MHZ        = 100;
  localparam int          RST_HOLD_NS    = 1000;
  localparam int          RST_HOLD_CYC   = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int          CFG_PULSE_NS   = 1000;
  localparam int          CFG_PULSE_CYC  = (CFG_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int          CNT_W          = 8;
  localparam int          IR_W           = 8;
  localparam logic [IR_W-1:0] IR_RESET_VAL = 8'hff;
  localparam logic [IR_W-1:0] INS_BYPASS   = 8'hff;
  localparam logic [IR_W-1:0] INS_CONFIG   = 8'hee;
  localparam logic [IR_W-1:0] INS_ISP_EN   = 8'he8;
  localparam logic [IR_W-1:0] INS_ISP_DIS  = 8'hf0;
  localparam logic [IR_W-1:0] INS_PROGRAM  = 8'hea;
  localparam logic [IR_W-1:0] INS_CLAMP    = 8'hfa;
  localparam logic [IR_W-1:0] IR_CAPTURE   = 8'h01;
  localparam int          SYNC_W         = 7;
  localparam int          PIN_CCLK       = 0;
  localparam int          PIN_CSEL       = 1;
  localparam int          PIN_OE         = 2;
  localparam int          PIN_CE_N       = 3;
  localparam int          PIN_TCK        = 4;
  localparam int          PIN_TMS        = 5;
  localparam int          PIN_TDI        = 6;

  typedef enum logic [3:0] {
    TAP_EXIT2_DR  = 4'h0, TAP_EXIT1_DR  = 4'h1, TAP_SHIFT_DR  = 4'h2, TAP_PAUSE_DR  = 4'h3,
    TAP_SEL_IR    = 4'h4, TAP_UPDATE_DR = 4'h5, TAP_CAPT_DR   = 4'h6, TAP_SEL_DR    = 4'h7,
    TAP_EXIT2_IR  = 4'h8, TAP_EXIT1_IR  = 4'h9, TAP_SHIFT_IR  = 4'ha, TAP_PAUSE_IR  = 4'hb,
    TAP_IDLE      = 4'hc, TAP_UPDATE_IR = 4'hd, TAP_CAPT_IR   = 4'he, TAP_RESET     = 4'hf
  } scpr_tap_type;
endpackage

// ===== sim/scpr_cfg_host.sv
// Model of the configuration logic beside the readout
`timescale 1ns/100ps
module scpr_cfg_host (
  input  wire logic mclk_i,
  input  wire logic pull_low_i,
  input  wire logic dev_oe_n_i,
  input  wire logic data_i,
  input  wire logic data_oe_n_i,
  output logic      cfg_clk_o,
  output logic      wire_o
);
  logic last_q = 1'b0;
  initial cfg_clk_o = 1'b0;
  // Open-drain wire with pull-up
  assign wire_o = !(pull_low_i || !dev_oe_n_i);
  // Reads the line, then one clock step; a floated line reads inverted
  task automatic step_rd(output logic b);
    b = data_oe_n_i ? ~last_q : data_i;
    last_q = b;
    @(posedge mclk_i) cfg_clk_o <= 1'b1;
    repeat (4) @(posedge mclk_i);
    cfg_clk_o <= 1'b0;
    repeat (4) @(posedge mclk_i);
  endtask
endmodule // scpr_cfg_host

// ===== sim/scpr_readout_monitor.sv
// Port checker for the configuration readout
`timescale 1ns/100ps
module scpr_readout_chk
  import scpr_pkg::*;
#(parameter int AW = 8) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic oe_reset_i,
  input wire logic ce_n_i,
  input wire logic serial_data_oe_n_o,
  input wire logic oe_reset_o,
  input wire logic oe_reset_oe_n_o,
  input wire logic chain_enable_out_n_o,
  input wire logic fpga_config_pulse_o,
  input wire logic fpga_config_pulse_oe_n_o,
  input wire logic in_system_prog_state_o
);
  logic [7:0] pc_q, pc_d, rc_q, rc_d;
  // Pulse length and cycles since reset release
  always_comb begin
    pc_d = fpga_config_pulse_oe_n_o ? 8'h00 : pc_q + 8'h01;
    rc_d = (rc_q == 8'hff) ? rc_q : rc_q + 8'h01;
  end
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pc_q <= 8'h00;
      rc_q <= 8'h00;
    end else begin
      pc_q <= pc_d;
      rc_q <= rc_d;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  chk_oe_float: assert property (!oe_reset_i [*6] |-> serial_data_oe_n_o)
    else $error("data drives with oe low");
  chk_ce_float: assert property (ce_n_i [*6] |-> serial_data_oe_n_o)
    else $error("data drives with ce high");
  chk_isp_float: assert property (in_system_prog_state_o [*3] |-> serial_data_oe_n_o)
    else $error("data drives in isp");
  chk_data_on: assert property ((oe_reset_i && !ce_n_i && !in_system_prog_state_o) [*6]
    |-> !serial_data_oe_n_o)
    else $error("data not driven");
  chk_ceo_ce: assert property (ce_n_i [*6] |-> chain_enable_out_n_o)
    else $error("chain low with ce high");
  chk_ceo_oe: assert property (!oe_reset_i [*6] |-> chain_enable_out_n_o)
    else $error("chain low with oe low");
  chk_ceo_cause: assert property ($fell(chain_enable_out_n_o)
    |-> !$past(ce_n_i, 4) && $past(oe_reset_i, 4))
    else $error("chain fell without enable");
  chk_od_low: assert property (!oe_reset_o && !fpga_config_pulse_o)
    else $error("open drain drives high");
  chk_pulse_len: assert property ($rose(fpga_config_pulse_oe_n_o)
    |-> int'(pc_q) == CFG_PULSE_CYC)
    else $error("config pulse length");
  chk_rst_hold: assert property (int'(rc_q) < RST_HOLD_CYC - 1 |-> !oe_reset_oe_n_o)
    else $error("reset hold released early");
  cover property ($fell(fpga_config_pulse_oe_n_o));
  cover property ($fell(chain_enable_out_n_o));
  cover property ($rose(in_system_prog_state_o));
endmodule // scpr_readout_chk

bind scpr_readout scpr_readout_chk #(.AW(AW)) i_scpr_readout_chk (.*);

// ===== sim/tb.sv
// Self-checking bench for the configuration readout
`timescale 1ns/100ps
module tb;
  import scpr_pkg::*;
  logic mclk_i = 0, sys_rst_i = 1, cfg_clk_i, cfg_clk_sel_i = 1, ce_n_i = 1, oe_reset_i;
  logic tck_i = 0, tms_i = 1, tdi_i = 0, pull_low = 0, d, doe, roe, chain_enable_out, cfp, tdo, isp, b;
  logic [15:0] mem;
  logic [31:0] rnd = 32'h1e4d;
  int          error_cnt = 0, n_checks = 0;
  always #5 mclk_i = ~mclk_i;
  scpr_readout #(.AW(4)) i_scpr_readout (.serial_data_out_o(d), .serial_data_oe_n_o(doe),
    .oe_reset_o(), .oe_reset_oe_n_o(roe), .chain_enable_out_n_o(chain_enable_out), .fpga_config_pulse_o(),
    .fpga_config_pulse_oe_n_o(cfp), .tdo_o(tdo), .in_system_prog_state_o(isp), .*);
  scpr_cfg_host i_scpr_cfg_host (.mclk_i, .pull_low_i(pull_low), .dev_oe_n_i(roe), .data_i(d),
    .data_oe_n_i(doe), .cfg_clk_o(cfg_clk_i), .wire_o(oe_reset_i));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic st(output logic o);
    i_scpr_cfg_host.step_rd(o);
  endtask
  task automatic tap(input logic m, input logic v, output logic o);
    tms_i <= m;
    tdi_i <= v;
    cyc(6);
    o = tdo;
    tck_i <= 1'b1;
    cyc(6);
    tck_i <= 1'b0;
  endtask
  task automatic ir(input logic [7:0] c);
    logic o;
    logic [7:0] cap;
    for (int i = 0; i < 4; i++) tap(i < 2, 1'b0, o);
    for (int i = 0; i < 8; i++) tap(i == 7, c[i], cap[i]);
    chk(cap, IR_CAPTURE);
    for (int i = 0; i < 2; i++) tap(i == 0, 1'b0, o);
  endtask
  task automatic dr(input logic v);
    logic o;
    logic [5:0] s = 6'h19;
    for (int i = 0; i < 6; i++) tap(s[i], v, o);
  endtask
  initial begin
    cyc(5);
    chk({tdo, isp, chain_enable_out, roe, doe, cfp}, 8'h2b);
    sys_rst_i <= 1'b0;
    cyc(110);
    ce_n_i <= 1'b0;
    cyc(8);
    chk({oe_reset_i, doe}, 8'h02);
    tap(1'b0, 1'b0, b);
    ir(INS_ISP_EN);
    cyc(8);
    chk({isp, doe}, 8'h03);
    ir(INS_PROGRAM);
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      mem[i] = (i == 0) ? 1'b0 : (i == 2 || i == 3) ? 1'b1 : rnd[0];
      dr(mem[i]);
    end
    ir(INS_ISP_DIS);
    pull_low <= 1'b1;
    cyc(8);
    chk({isp, doe, chain_enable_out}, 8'h03);
    pull_low <= 1'b0;
    cyc(8);
    for (int i = 0; i < 16; i++) begin
      chk(chain_enable_out, 1'b1);
      st(b);
      chk(b, mem[i]);
    end
    cyc(4);
    chk(chain_enable_out, 1'b0);
    ce_n_i <= 1'b1;
    cyc(6);
    chk(doe, 1'b1);
    chk(chain_enable_out, 1'b1);
    cfg_clk_sel_i <= 1'b0;
    ce_n_i <= 1'b0;
    for (int i = 0; i < 3; i++) st(b);
    cfg_clk_sel_i <= 1'b1;
    cyc(8);
    st(b);
    chk(b, mem[0]);
    st(b);
    pull_low <= 1'b1;
    cyc(6);
    chk(doe, 1'b1);
    pull_low <= 1'b0;
    cyc(8);
    st(b);
    chk(b, mem[0]);
    ir(INS_CONFIG);
    chk(cfp, 1'b0);
    cyc(100);
    chk(cfp, 1'b1);
    end_sim();
  end
  initial begin
    cyc(20000);
    error_cnt++;
    end_sim();
  end
endmodule // tb
